// File: dcfc_credit_ctrl.sv
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
// Contract
// - argument-less data request answers with the current send credit count.
// - credit grant adds its frame amount to the counter; sequence number optional.
// - each sent data frame takes one credit; no data frames sent at zero credits.
// - a grant of all ones clears the send credit counter.
// - configuration-side credit query returns same count, destination untouched.
// - every accepted data request makes its sender the only data destination.
// - credit drop discards credits; any excess stays pending against later grants.
// - credit drop of zero keeps credits and clears the pending drop count.
// - frame drop reads remaining discard count, or loads a new count.
// - nonzero frame discard count discards consecutive event data frames, counting down.
// - configuration, monitoring and pedestal-bound frames are never discarded.
// - request drop count read or loaded; nonzero ignores consecutive incoming requests.
// - request without sequence number resets the expected sequence to zero.
// - sequence mismatch adds the number of lost requests to the miss counter.
// - miss counter readable; increment, decrement or load, zero clears.
module dcfc_credit_ctrl
  import dcfc_pkg::*;
(
  // clock and reset
  input  wire logic             REF_CLK,
  input  wire logic             RST_N,
  // register port
  input  wire logic [ADR_W-1:0] REG_ADDR,
  input  wire logic [DAT_W-1:0] REG_WDATA,
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  output logic      [DAT_W-1:0] REG_RDATA,
  // incoming data request commands (one-cycle strobe)
  input  wire logic             REQ_VALID,
  input  wire logic             REQ_HAS_CREDIT,
  input  wire logic [CNT_W-1:0] REQ_CREDIT_AMOUNT,
  input  wire logic             REQ_HAS_SEQ,
  input  wire logic [SEQ_W-1:0] REQ_SEQUENCE_NUMBER,
  input  wire logic [DAT_W-1:0] REQ_RETURN_PATH,
  // answer to an argument-less request
  output logic                  REPLY_VALID,
  output logic      [CNT_W-1:0] REPLY_CREDITS,
  // outgoing frames from the framer
  input  wire logic             FRM_VALID,
  input  wire logic             FRM_IS_DAQ_DATA,
  output logic                  FRM_READY,
  output logic                  FRM_SEND,
  output logic                  FRM_DISCARD,
  // data destination
  output logic      [DAT_W-1:0] DEST_PATH,
  // interrupt
  output logic                  IRQ
);

  typedef struct packed {
    // credit and test-hook counters
    logic [CNT_W-1:0] credits;
    logic [CNT_W-1:0] drop_pend;
    logic [CNT_W-1:0] frm_drop;
    logic [CNT_W-1:0] req_drop;
    logic [CNT_W-1:0] miss;
    // request tracking
    logic [SEQ_W-1:0] exp_seq;
    logic [DAT_W-1:0] dest;
    // interrupt
    logic [IRQ_W-1:0] irq_sts;
    logic [IRQ_W-1:0] irq_msk;
    // registered outputs
    logic [DAT_W-1:0] rdata;
    logic             reply_vld;
    logic [CNT_W-1:0] reply_cnt;
    logic             frm_send;
    logic             frm_disc;
    logic             irq;
    logic             frm_rdy;
  } dcfc_state_t;

  dcfc_state_t s_q;
  dcfc_state_t s_d;

  logic             req_take;
  logic             frm_is_data;
  logic             frm_may_go;
  logic [CNT_W-1:0] grant;
  logic [CNT_W-1:0] net;
  logic [CNT_W-1:0] lost;
  logic [IRQ_W-1:0] ev;

  always_comb
  begin
    s_d        = s_q;
    grant      = CNT_ZERO;
    net        = CNT_ZERO;
    lost       = CNT_ZERO;
    ev         = '0;
    req_take   = 1'b0;
    frm_is_data = FRM_VALID && FRM_IS_DAQ_DATA;
    frm_may_go = s_q.credits != CNT_ZERO;

    // strobes and read data last one cycle, so a stale word never looks fresh
    s_d.reply_vld = 1'b0;
    s_d.frm_send  = 1'b0;
    s_d.frm_disc  = 1'b0;
    s_d.rdata     = {DAT_W{1'b0}};

    // frame path; non-data frames pass untouched and consume no credit
    if (FRM_VALID && !FRM_IS_DAQ_DATA)
    begin
      s_d.frm_send = 1'b1;
    end
    else if (frm_is_data && s_q.frm_drop != CNT_ZERO)
    begin
      s_d.frm_disc = 1'b1;
      s_d.frm_drop = s_q.frm_drop - CNT_ONE;
    end
    else if (frm_is_data && frm_may_go)
    begin
      s_d.frm_send = 1'b1;
      s_d.credits  = s_q.credits - CNT_ONE;
      // only the send that spends the last credit raises the empty event
      if (s_q.credits == CNT_ONE)
      begin
        ev[IRQ_EMPTY] = 1'b1;
      end
    end

    // incoming request; dropped ones are consumed with no effect beyond the drop event
    if (REQ_VALID)
    begin
      if (s_q.req_drop != CNT_ZERO)
      begin
        // the expected sequence is left alone, so the next numbered request shows the gap
        s_d.req_drop   = s_q.req_drop - CNT_ONE;
        ev[IRQ_DROP]   = 1'b1;
      end
      else
      begin
        req_take = 1'b1;
      end
    end

    if (req_take)
    begin
      // the newest requester replaces any earlier destination
      s_d.dest = REQ_RETURN_PATH;

      // sequence check
      if (!REQ_HAS_SEQ)
      begin
        s_d.exp_seq = SEQ_ZERO;
      end
      else
      begin
        if (REQ_SEQUENCE_NUMBER != s_q.exp_seq)
        begin
          // gap modulo 256 is how many requests went missing
          lost         = {{(CNT_W-SEQ_W){1'b0}}, REQ_SEQUENCE_NUMBER - s_q.exp_seq};
          s_d.miss     = s_q.miss + lost;
          ev[IRQ_MISS] = 1'b1;
        end
        // eight-bit sum, so the top value wraps to zero
        s_d.exp_seq = REQ_SEQUENCE_NUMBER + SEQ_ONE;
      end

      // credit argument
      if (!REQ_HAS_CREDIT)
      begin
        s_d.reply_vld = 1'b1;
        s_d.reply_cnt = s_q.credits;
      end
      else if (REQ_CREDIT_AMOUNT == CREDIT_CLEAR_CODE)
      begin
        // pending drops are kept for later grants
        s_d.credits = CNT_ZERO;
      end
      else
      begin
        grant = REQ_CREDIT_AMOUNT;
        // pending drops eat into returned credits first
        if (s_q.drop_pend >= grant)
        begin
          s_d.drop_pend = s_q.drop_pend - grant;
        end
        else
        begin
          net           = grant - s_q.drop_pend;
          s_d.drop_pend = CNT_ZERO;
          s_d.credits   = s_d.credits + net;
        end
      end
    end

    // register writes
    if (REG_WR)
    begin
      case (REG_ADDR)
        REG_DROP_CREDITS:
        begin
          // acts on the credits left after this cycle's frame and grant
          if (REG_WDATA[CNT_W-1:0] == CNT_ZERO)
          begin
            s_d.drop_pend = CNT_ZERO;
          end
          else if (REG_WDATA[CNT_W-1:0] > s_d.credits)
          begin
            s_d.drop_pend = REG_WDATA[CNT_W-1:0] - s_d.credits;
            s_d.credits   = CNT_ZERO;
          end
          else
          begin
            s_d.credits = s_d.credits - REG_WDATA[CNT_W-1:0];
          end
        end
        REG_DROP_FRAMES:
        begin
          s_d.frm_drop = REG_WDATA[CNT_W-1:0];
        end
        REG_DROP_REQS:
        begin
          s_d.req_drop = REG_WDATA[CNT_W-1:0];
        end
        REG_MISS_CNT:
        begin
          s_d.miss = REG_WDATA[CNT_W-1:0];
        end
        REG_MISS_CMD:
        begin
          if (REG_WDATA[1:0] == MISS_CMD_INC)
          begin
            s_d.miss = s_d.miss + CNT_ONE;
          end
          else if (REG_WDATA[1:0] == MISS_CMD_DEC)
          begin
            // below zero it wraps; the counter is a test aid that software may set freely
            s_d.miss = s_d.miss - CNT_ONE;
          end
        end
        REG_IRQ_STATUS:
        begin
          s_d.irq_sts = s_q.irq_sts & ~REG_WDATA[IRQ_W-1:0];
        end
        REG_IRQ_MASK:
        begin
          s_d.irq_msk = REG_WDATA[IRQ_W-1:0];
        end
        default:
        begin
          // read-only and unmapped offsets ignore writes
        end
      endcase
    end

    // set wins over a clear in the same cycle
    s_d.irq_sts = s_d.irq_sts | ev;
    s_d.irq     = |(s_d.irq_sts & s_d.irq_msk);

    // ready is taken from the next counts, so it stays a flop output and still drops
    // in the very cycle after the last credit or discard is used; it speaks for data frames
    s_d.frm_rdy = s_d.frm_drop != CNT_ZERO || s_d.credits != CNT_ZERO;

    // register reads; the credit query has no effect on the destination
    if (REG_RD)
    begin
      case (REG_ADDR)
        REG_CREDITS:
        begin
          s_d.rdata = {{(DAT_W-CNT_W){1'b0}}, s_q.credits};
        end
        REG_DROP_CREDITS:
        begin
          s_d.rdata = {{(DAT_W-CNT_W){1'b0}}, s_q.drop_pend};
        end
        REG_DROP_FRAMES:
        begin
          s_d.rdata = {{(DAT_W-CNT_W){1'b0}}, s_q.frm_drop};
        end
        REG_DROP_REQS:
        begin
          s_d.rdata = {{(DAT_W-CNT_W){1'b0}}, s_q.req_drop};
        end
        REG_MISS_CNT:
        begin
          s_d.rdata = {{(DAT_W-CNT_W){1'b0}}, s_q.miss};
        end
        REG_IRQ_STATUS:
        begin
          s_d.rdata = {{(DAT_W-IRQ_W){1'b0}}, s_q.irq_sts};
        end
        REG_IRQ_MASK:
        begin
          s_d.rdata = {{(DAT_W-IRQ_W){1'b0}}, s_q.irq_msk};
        end
        REG_EXP_SEQ:
        begin
          s_d.rdata = {{(DAT_W-SEQ_W){1'b0}}, s_q.exp_seq};
        end
        REG_DEST:
        begin
          s_d.rdata = s_q.dest;
        end
        default:
        begin
          s_d.rdata = {DAT_W{1'b0}};
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      s_q.credits   <= CNT_ZERO;
      s_q.drop_pend <= CNT_ZERO;
      s_q.frm_drop  <= CNT_ZERO;
      s_q.req_drop  <= CNT_ZERO;
      s_q.miss      <= CNT_ZERO;
      s_q.exp_seq   <= SEQ_ZERO;
      // the destination holds a neutral token until a request names one
      s_q.dest      <= DEST_RESET;
      s_q.irq_sts   <= {IRQ_W{1'b0}};
      s_q.irq_msk   <= {IRQ_W{1'b0}};
      s_q.rdata     <= {DAT_W{1'b0}};
      s_q.reply_vld <= 1'b0;
      s_q.reply_cnt <= CNT_ZERO;
      s_q.frm_send  <= 1'b0;
      s_q.frm_disc  <= 1'b0;
      s_q.irq       <= 1'b0;
      s_q.frm_rdy   <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign FRM_READY     = s_q.frm_rdy;
  assign REG_RDATA     = s_q.rdata;
  assign REPLY_VALID   = s_q.reply_vld;
  assign REPLY_CREDITS = s_q.reply_cnt;
  assign FRM_SEND      = s_q.frm_send;
  assign FRM_DISCARD   = s_q.frm_disc;
  assign DEST_PATH     = s_q.dest;
  assign IRQ           = s_q.irq;

endmodule // dcfc_credit_ctrl

// File: dcfc_pkg.sv
package dcfc_pkg;

  localparam int CNT_W = 24;
  localparam int SEQ_W = 8;
  localparam int ADR_W = 4;
  localparam int DAT_W = 32;

  // credit grant encodings
  localparam logic [CNT_W-1:0] CREDIT_CLEAR_CODE = 24'hFFFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO          = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE           = 24'h000001;
  localparam logic [SEQ_W-1:0] SEQ_ZERO          = 8'h00;
  localparam logic [SEQ_W-1:0] SEQ_ONE           = 8'h01;

  // register map (register indices, numbered consecutively)
  localparam logic [ADR_W-1:0] REG_CREDITS      = 4'h0;
  localparam logic [ADR_W-1:0] REG_DROP_CREDITS = 4'h1;
  localparam logic [ADR_W-1:0] REG_DROP_FRAMES  = 4'h2;
  localparam logic [ADR_W-1:0] REG_DROP_REQS    = 4'h3;
  localparam logic [ADR_W-1:0] REG_MISS_CNT     = 4'h4;
  localparam logic [ADR_W-1:0] REG_MISS_CMD     = 4'h5;
  localparam logic [ADR_W-1:0] REG_IRQ_STATUS   = 4'h6;
  localparam logic [ADR_W-1:0] REG_IRQ_MASK     = 4'h7;
  localparam logic [ADR_W-1:0] REG_EXP_SEQ      = 4'h8;
  localparam logic [ADR_W-1:0] REG_DEST         = 4'h9;

  // miss counter command codes written to REG_MISS_CMD
  localparam logic [1:0] MISS_CMD_INC = 2'h1;
  localparam logic [1:0] MISS_CMD_DEC = 2'h2;

  // interrupt bit positions
  localparam int IRQ_MISS  = 0;
  localparam int IRQ_EMPTY = 1;
  localparam int IRQ_DROP  = 2;
  localparam int IRQ_W     = 3;

  localparam logic [DAT_W-1:0] DEST_RESET = 32'h00000000;

endpackage

// File: dcfc_properties.sv
`timescale 1ns/1ps
module dcfc_checker
  import dcfc_pkg::*;
(
  // clock and reset
  input wire logic             REF_CLK,
  input wire logic             RST_N,
  // watched ports
  input wire logic [ADR_W-1:0] REG_ADDR,
  input wire logic             REG_RD,
  input wire logic             REQ_VALID,
  input wire logic             REQ_HAS_CREDIT,
  input wire logic             REPLY_VALID,
  input wire logic             FRM_VALID,
  input wire logic             FRM_IS_DAQ_DATA,
  input wire logic             FRM_READY,
  input wire logic             FRM_SEND,
  input wire logic             FRM_DISCARD,
  input wire logic [DAT_W-1:0] DEST_PATH
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_plain_frame;
    FRM_VALID && !FRM_IS_DAQ_DATA;
  endsequence
  sequence s_ready_data;
    FRM_VALID && FRM_IS_DAQ_DATA && FRM_READY;
  endsequence
  a_reply_needs_query: assert property (REPLY_VALID |-> $past(REQ_VALID) && !$past(REQ_HAS_CREDIT))
    else $error("reply without query");
  // guard on the past reset: the clear of the path during reset is not a request
  a_dest_on_request: assert property ($past(RST_N) && $changed(DEST_PATH) |-> $past(REQ_VALID))
    else $error("path moved without request");
  a_query_keeps_dest: assert property (REG_RD && REG_ADDR == REG_CREDITS && !REQ_VALID |=> $stable(DEST_PATH))
    else $error("credit query moved path");
  a_plain_frame_sent: assert property (s_plain_frame |=> FRM_SEND && !FRM_DISCARD)
    else $error("plain frame not sent");
  a_discard_data_only: assert property (FRM_DISCARD |-> $past(FRM_VALID) && $past(FRM_IS_DAQ_DATA))
    else $error("bad discard");
  a_stall_no_send: assert property (FRM_VALID && FRM_IS_DAQ_DATA && !FRM_READY |=> !FRM_SEND && !FRM_DISCARD)
    else $error("frame sent without credit");
  a_send_needs_frame: assert property (FRM_SEND |-> $past(FRM_VALID) && !FRM_DISCARD)
    else $error("send without frame");
  a_ready_data_out: assert property (s_ready_data |=> FRM_SEND != FRM_DISCARD)
    else $error("ready frame lost");
endmodule // dcfc_checker

bind dcfc_credit_ctrl dcfc_checker u_chk (.REF_CLK, .RST_N, .REG_ADDR, .REG_RD, .REQ_VALID, .REQ_HAS_CREDIT,
  .REPLY_VALID, .FRM_VALID, .FRM_IS_DAQ_DATA, .FRM_READY, .FRM_SEND, .FRM_DISCARD, .DEST_PATH);

// File: dcfc_daq_pc.sv
`timescale 1ns/1ps
module dcfc_daq_pc
  import dcfc_pkg::*;
(
  input  wire logic             clk,
  output logic                  req_valid,
  output logic                  has_credit,
  output logic      [CNT_W-1:0] credit_amount,
  output logic                  has_seq,
  output logic      [SEQ_W-1:0] request_sequence_number,
  output logic      [DAT_W-1:0] return_path
);
  logic [SEQ_W-1:0] next_seq = SEQ_ZERO;
  initial {req_valid, has_credit, credit_amount, has_seq, request_sequence_number, return_path} = '0;
  // lost above zero skips numbers as if commands vanished on the link
  task automatic send(input logic c, input logic [CNT_W-1:0] a, input logic s, input logic [DAT_W-1:0] p,
                      input int lost);
    @(posedge clk);
    req_valid <= 1'b1;
    has_credit <= c;
    credit_amount <= a;
    has_seq <= s;
    request_sequence_number <= next_seq + SEQ_W'(lost);
    return_path <= p;
    next_seq = s ? next_seq + SEQ_W'(lost) + SEQ_ONE : SEQ_ZERO;
    @(posedge clk);
    req_valid <= 1'b0;
    {has_credit, has_seq} <= ~{c, s};
    {credit_amount, return_path} <= ~{a, p};
    request_sequence_number <= ~request_sequence_number;
  endtask
endmodule // dcfc_daq_pc

// File: tb.sv
`timescale 1ns/1ps
module tb
  import dcfc_pkg::*;
;
  logic             REF_CLK = 1'b0;
  logic             RST_N = 1'b0;
  logic             REG_WR = 1'b0;
  logic             REG_RD = 1'b0;
  logic             FRM_VALID = 1'b0;
  logic             FRM_IS_DAQ_DATA = 1'b0;
  logic [ADR_W-1:0] REG_ADDR = 4'h0;
  logic [DAT_W-1:0] REG_WDATA = 32'h00000000;
  logic [DAT_W-1:0] REG_RDATA, DEST_PATH, REQ_RETURN_PATH, path;
  logic [CNT_W-1:0] REPLY_CREDITS, REQ_CREDIT_AMOUNT;
  logic [SEQ_W-1:0] REQ_SEQUENCE_NUMBER;
  logic             REPLY_VALID, FRM_READY, FRM_SEND, FRM_DISCARD, IRQ, REQ_VALID, REQ_HAS_CREDIT, REQ_HAS_SEQ;
  int               mismatches = 0;
  int               n_compared = 0;
  int               seed = 22;
  int               n;
  always #2.5 REF_CLK = ~REF_CLK;
  dcfc_credit_ctrl u_dut (.REF_CLK, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .REQ_VALID,
    .REQ_HAS_CREDIT, .REQ_CREDIT_AMOUNT, .REQ_HAS_SEQ, .REQ_SEQUENCE_NUMBER, .REQ_RETURN_PATH, .REPLY_VALID,
    .REPLY_CREDITS, .FRM_VALID, .FRM_IS_DAQ_DATA, .FRM_READY, .FRM_SEND, .FRM_DISCARD, .DEST_PATH, .IRQ);
  dcfc_daq_pc u_pc (.clk(REF_CLK), .req_valid(REQ_VALID), .has_credit(REQ_HAS_CREDIT),
    .credit_amount(REQ_CREDIT_AMOUNT), .has_seq(REQ_HAS_SEQ), .request_sequence_number(REQ_SEQUENCE_NUMBER),
    .return_path(REQ_RETURN_PATH));
  function automatic logic [DAT_W-1:0] gap(input logic [SEQ_W-1:0] got, input logic [SEQ_W-1:0] exp);
    return DAT_W'(SEQ_W'(got - exp));
  endfunction
  task automatic chk(input logic [DAT_W-1:0] got, input logic [DAT_W-1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    @(posedge REF_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge REF_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] e);
    @(posedge REF_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge REF_CLK);
    REG_RD <= 1'b0;
    #1 chk(REG_RDATA, e);
  endtask
  task automatic frm(input logic d, input logic [1:0] e);
    @(posedge REF_CLK);
    FRM_VALID <= 1'b1;
    FRM_IS_DAQ_DATA <= d;
    @(posedge REF_CLK);
    FRM_VALID <= 1'b0;
    #1 chk(DAT_W'({FRM_SEND, FRM_DISCARD}), DAT_W'(e));
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge REF_CLK);
    mismatches++;
    tally_and_finish;
  end
  initial
  begin
    path = $random(seed);
    n = 1 + ($random(seed) & 7);
    repeat (4) @(posedge REF_CLK);
    RST_N <= 1'b1;
    rd(REG_DEST, DEST_RESET);
    u_pc.send(1'b1, CNT_W'(n), 1'b0, ~path, 0);
    u_pc.send(1'b1, CREDIT_CLEAR_CODE, 1'b0, path, 0);
    rd(REG_CREDITS, 32'h0);
    u_pc.send(1'b1, CNT_W'(n), 1'b0, path, 0);
    u_pc.send(1'b0, CNT_ZERO, 1'b0, path, 0);
    #1 chk(DAT_W'({REPLY_VALID, REPLY_CREDITS}), DAT_W'({1'b1, CNT_W'(n)}));
    chk(DEST_PATH, path);
    repeat (n) frm(1'b1, 2'b10);
    #1 chk(DAT_W'(FRM_READY), 32'h0);
    frm(1'b1, 2'b00);
    frm(1'b0, 2'b10);
    rd(REG_IRQ_STATUS, 32'h2);
    wr(REG_IRQ_MASK, 32'h2);
    repeat (2) @(posedge REF_CLK);
    #1 chk(DAT_W'(IRQ), 32'h1);
    wr(REG_IRQ_STATUS, 32'h2);
    repeat (2) @(posedge REF_CLK);
    #1 chk(DAT_W'(IRQ), 32'h0);
    $display("test credits done");
    u_pc.send(1'b1, 24'h000003, 1'b0, path, 0);
    wr(REG_DROP_CREDITS, 32'h5);
    rd(REG_CREDITS, 32'h0);
    rd(REG_DROP_CREDITS, 32'h2);
    u_pc.send(1'b1, 24'h000004, 1'b0, path, 0);
    rd(REG_CREDITS, 32'h2);
    wr(REG_DROP_CREDITS, 32'h7);
    wr(REG_DROP_CREDITS, 32'h0);
    rd(REG_DROP_CREDITS, 32'h0);
    u_pc.send(1'b1, 24'h000002, 1'b0, path, 0);
    rd(REG_CREDITS, 32'h2);
    wr(REG_DROP_FRAMES, 32'h2);
    rd(REG_DROP_FRAMES, 32'h2);
    frm(1'b1, 2'b01);
    frm(1'b0, 2'b10);
    frm(1'b1, 2'b01);
    frm(1'b1, 2'b10);
    rd(REG_DROP_FRAMES, 32'h0);
    rd(REG_CREDITS, 32'h1);
    $display("test drops done");
    wr(REG_DROP_REQS, 32'h1);
    u_pc.send(1'b1, 24'h000005, 1'b0, ~path, 0);
    rd(REG_CREDITS, 32'h1);
    rd(REG_DROP_REQS, 32'h0);
    chk(DEST_PATH, path);
    u_pc.send(1'b0, CNT_ZERO, 1'b0, path, 0);
    rd(REG_EXP_SEQ, 32'h0);
    u_pc.send(1'b0, CNT_ZERO, 1'b1, path, 0);
    u_pc.send(1'b0, CNT_ZERO, 1'b1, path, 1);
    rd(REG_MISS_CNT, gap(8'h02, 8'h01));
    rd(REG_EXP_SEQ, 32'h3);
    wr(REG_MISS_CMD, DAT_W'(MISS_CMD_INC));
    rd(REG_MISS_CNT, 32'h2);
    wr(REG_MISS_CMD, DAT_W'(MISS_CMD_DEC));
    rd(REG_MISS_CNT, 32'h1);
    wr(REG_MISS_CNT, 32'h0);
    u_pc.send(1'b0, CNT_ZERO, 1'b0, path, 0);
    u_pc.send(1'b0, CNT_ZERO, 1'b1, path, 255);
    rd(REG_MISS_CNT, gap(8'hFF, SEQ_ZERO));
    rd(REG_EXP_SEQ, 32'h0);
    rd(4'hF, 32'h0);
    $display("test requests done");
    tally_and_finish;
  end
endmodule // tb
